// ===== hpsel_pkg.sv
package hpsel_pkg;

   // clock and register port
   localparam int CLK_MHZ = 200;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] LINK_STAT_OFS = 12'h078;
   localparam logic [ADDR_W-1:0] SLOT_CTRL_OFS = 12'h080;
   localparam int LINK_ACTIVE_BIT = 29;
   localparam int CTRL_LO = 0;
   localparam int CTRL_HI = 15;
   localparam int STAT_LO = 16;
   localparam int STAT_HI = 31;

   // ports that may carry the slot controller
   localparam int HP_PORT_FIRST = 1;
   localparam int HP_PORT_LAST = 3;

   // slot control half word
   typedef struct packed {
      logic [4:0] rsvd_hi;
      logic pwr_off;
      logic [1:0] ind;
      logic [1:0] rsvd_mid;
      logic hp_int_en;
      logic cmd_en;
      logic pres_en;
      logic latch_en;
      logic rsvd_lo;
      logic btn_en;
   } hpsel_ctrl_t;

   // slot status half word
   typedef struct packed {
      logic [8:0] rsvd_hi;
      logic pres_st;
      logic latch_st;
      logic cmd;
      logic pres_chg;
      logic latch_chg;
      logic rsvd_lo;
      logic btn;
   } hpsel_stat_t;

   localparam logic [15:0] CTRL_RST = 16'h0400;
   localparam logic [15:0] STAT_RST = 16'h0000;

   // power indicator codes
   localparam logic [1:0] IND_OFF = 2'h0;
   localparam logic [1:0] IND_ON = 2'h1;
   localparam logic [1:0] IND_BLINK = 2'h2;

   // slot power sequencer states
   typedef enum logic [2:0] {
      PS_OFF = 3'b000,
      PS_UP_VALID = 3'b001,
      PS_UP_RST = 3'b010,
      PS_ON = 3'b011,
      PS_DN_CLK = 3'b100,
      PS_DN_PWR = 3'b101,
      PS_DN_WAIT = 3'b110
   } hpsel_pwr_state_t;

   // times in their own units
   localparam int T_DEBOUNCE_MS = 10;
   localparam int T_PWR_VALID_MS = 16;
   localparam int T_RST_REL_MS = 100;
   localparam int T_SEQ_US = 100;
   localparam int T_PWR_OFF_MS = 256;
   localparam int T_BLINK_MS = 500;

   // derived cycle counts
   localparam int CYC_PER_US = CLK_MHZ;
   localparam int CYC_PER_MS = 1000 * CLK_MHZ;
   localparam int DEBOUNCE_CYC = T_DEBOUNCE_MS * CYC_PER_MS;
   localparam int PWR_VALID_CYC = T_PWR_VALID_MS * CYC_PER_MS;
   localparam int RST_REL_CYC = T_RST_REL_MS * CYC_PER_MS;
   localparam int SEQ_CYC = T_SEQ_US * CYC_PER_US;
   localparam int PWR_OFF_CYC = T_PWR_OFF_MS * CYC_PER_MS;
   localparam int BLINK_CYC = T_BLINK_MS * CYC_PER_MS;

   localparam int DBC_LATCH = 0;
   localparam int DBC_BTN = 1;
   localparam int DBC_N = 2;

endpackage

// ===== hpsel_slot.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps

// Overview of operation
// - Board insertion sets presence state and presence changed; removal clears presence state and sets presence changed.
// - Once software clears the last enabled pending flag after a sent interrupt, a de-assertion message goes out if hot plug interrupts are enabled.
// - Latch lock clears the latch state flag, unlock sets it, and either sets latch changed and may interrupt.
// - An attention button press sets the button pressed flag and may interrupt.
// - Writing 10b to the indicator field makes the indicator blink and sets command completed.
// - Writing 01b to the indicator field turns the indicator on steadily and sets command completed.
// - Writing 00b to the indicator field turns the indicator off and sets command completed.
// - Clearing the power control bit powers the slot up and sets command completed after the power valid delay.
// - Setting the power control bit powers the slot off and sets command completed 256 ms later.
// - The link status word at 78h carries the link active bit at bit 29.
// - The slot logic exists only on ports 1 to 3 configured as downstream ports.
// - Latch and button changes are taken only after 10 ms of stable level.
// - At power off the slot reset asserts first, the reference clock stops 100 us later and power 100 us after that.
// - The power control bit sits at bit 10 of 80h and a 1 requests power down.
module hpsel_slot
   import hpsel_pkg::*;
#(
   parameter int PORT_NUM = 1,
   parameter int DEBOUNCE_P = DEBOUNCE_CYC,
   parameter int PWR_VALID_P = PWR_VALID_CYC,
   parameter int RST_REL_P = RST_REL_CYC,
   parameter int SEQ_P = SEQ_CYC,
   parameter int PWR_OFF_P = PWR_OFF_CYC,
   parameter int BLINK_P = BLINK_CYC
) (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // port configuration and link
   input wire logic port_is_downstream,
   input wire logic link_active,
   // slot sense inputs, active low
   input wire logic presence_detect_n,
   input wire logic latch_sense_in_n,
   input wire logic attention_button_in_n,
   // slot control outputs, active low
   output logic slot_reset_out_n,
   output logic slot_refclk_enable_out_n,
   output logic slot_power_enable_out_n,
   output logic power_indicator_out_n,
   // interrupt messages
   output logic int_assert_msg,
   output logic int_deassert_msg
);

   localparam bit PORT_OK = (PORT_NUM >= HP_PORT_FIRST) &&
      (PORT_NUM <= HP_PORT_LAST);
   // idle levels after reset: button released, latch locked
   localparam int DBC_W = DBC_N;

   function automatic logic flag_upd(input logic set_i, input logic cur_i,
      input logic clr_i);
      flag_upd = set_i | (cur_i & ~clr_i);
   endfunction

   hpsel_ctrl_t ctrl_r;
   hpsel_stat_t stat_r;
   hpsel_ctrl_t ctrl_wr;
   hpsel_stat_t stat_clr;
   hpsel_pwr_state_t state_r;
   logic hp_present;
   logic ctrl_write;
   logic pwr_on_req;
   logic pwr_off_req;
   logic ind_cmd_done;
   logic pwr_cmd_done_r;
   logic [31:0] tmr_r;
   logic [31:0] dbc_cnt_r [DBC_N];
   logic [DBC_N-1:0] dbc_raw;
   logic [DBC_N-1:0] dbc_stable_r;
   logic [DBC_N-1:0] dbc_chg_r;
   logic btn_press;
   logic pres_prev_r;
   logic [31:0] blink_cnt_r;
   logic blink_ph_r;
   logic pend;
   logic int_sent_r;
   logic [DATA_W-1:0] rdata_nxt;

   assign hp_present = PORT_OK && port_is_downstream;
   assign ctrl_wr = hpsel_ctrl_t'(reg_wdata[CTRL_HI:CTRL_LO]);
   assign ctrl_write = hp_present && reg_wr && (reg_addr == SLOT_CTRL_OFS);
   assign stat_clr = ctrl_write ?
      hpsel_stat_t'(reg_wdata[STAT_HI:STAT_LO]) : hpsel_stat_t'(STAT_RST);
   assign pwr_on_req = ctrl_write && ctrl_r.pwr_off && !ctrl_wr.pwr_off;
   assign pwr_off_req = ctrl_write && !ctrl_r.pwr_off && ctrl_wr.pwr_off;
   // a write that clears status flags is an acknowledge, not a command
   assign ind_cmd_done = ctrl_write && !pwr_on_req && !pwr_off_req &&
      !(|stat_clr);
   assign dbc_raw = {attention_button_in_n, latch_sense_in_n};
   assign btn_press = dbc_chg_r[DBC_BTN] && !dbc_stable_r[DBC_BTN];
   assign pend = (stat_r.btn && ctrl_r.btn_en) ||
      (stat_r.latch_chg && ctrl_r.latch_en) ||
      (stat_r.pres_chg && ctrl_r.pres_en) ||
      (stat_r.cmd && ctrl_r.cmd_en);

   // slot control register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_r <= hpsel_ctrl_t'(CTRL_RST);
      end else if (ce) begin
         if (!hp_present) begin
            ctrl_r <= hpsel_ctrl_t'(CTRL_RST);
         end else if (ctrl_write) begin
            ctrl_r <= ctrl_wr;
            ctrl_r.rsvd_hi <= '0;
            ctrl_r.rsvd_mid <= '0;
            ctrl_r.rsvd_lo <= 1'b0;
         end
      end
   end

   // debounce of latch and button
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dbc_stable_r <= DBC_W'(1 << DBC_BTN);
         dbc_chg_r <= '0;
         for (int i = 0; i < DBC_N; i++) begin
            dbc_cnt_r[i] <= '0;
         end
      end else if (ce) begin
         for (int i = 0; i < DBC_N; i++) begin
            dbc_chg_r[i] <= 1'b0;
            if (dbc_raw[i] == dbc_stable_r[i]) begin
               dbc_cnt_r[i] <= '0;
            end else if (dbc_cnt_r[i] == 32'(DEBOUNCE_P - 1)) begin
               dbc_cnt_r[i] <= '0;
               dbc_stable_r[i] <= dbc_raw[i];
               dbc_chg_r[i] <= hp_present;
            end else begin
               dbc_cnt_r[i] <= dbc_cnt_r[i] + 32'h1;
            end
         end
      end
   end

   // slot status register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stat_r <= hpsel_stat_t'(STAT_RST);
         pres_prev_r <= 1'b0;
      end else if (ce) begin
         if (!hp_present) begin
            stat_r <= hpsel_stat_t'(STAT_RST);
            pres_prev_r <= 1'b0;
         end else begin
            pres_prev_r <= !presence_detect_n;
            stat_r.pres_st <= pres_prev_r;
            stat_r.pres_chg <= flag_upd(pres_prev_r != stat_r.pres_st,
               stat_r.pres_chg, stat_clr.pres_chg);
            stat_r.latch_st <= dbc_stable_r[DBC_LATCH];
            stat_r.latch_chg <= flag_upd(dbc_chg_r[DBC_LATCH],
               stat_r.latch_chg, stat_clr.latch_chg);
            stat_r.btn <= flag_upd(btn_press, stat_r.btn,
               stat_clr.btn);
            stat_r.cmd <= flag_upd(ind_cmd_done || pwr_cmd_done_r,
               stat_r.cmd, stat_clr.cmd);
         end
      end
   end

   // slot power sequencer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= PS_OFF;
         tmr_r <= '0;
         pwr_cmd_done_r <= 1'b0;
         slot_reset_out_n <= 1'b0;
         slot_refclk_enable_out_n <= 1'b1;
         slot_power_enable_out_n <= 1'b1;
      end else if (ce) begin
         pwr_cmd_done_r <= 1'b0;
         if (!hp_present) begin
            state_r <= PS_OFF;
            tmr_r <= '0;
            slot_reset_out_n <= 1'b0;
            slot_refclk_enable_out_n <= 1'b1;
            slot_power_enable_out_n <= 1'b1;
         end else if (pwr_on_req) begin
            state_r <= PS_UP_VALID;
            tmr_r <= 32'(PWR_VALID_P - 1);
            slot_power_enable_out_n <= 1'b0;
         end else if (pwr_off_req) begin
            state_r <= PS_DN_CLK;
            tmr_r <= 32'(SEQ_P - 1);
            slot_reset_out_n <= 1'b0;
         end else if (tmr_r != '0) begin
            tmr_r <= tmr_r - 32'h1;
         end else begin
            case (state_r)
               PS_UP_VALID: begin
                  state_r <= PS_UP_RST;
                  tmr_r <= 32'(RST_REL_P - 1);
                  slot_refclk_enable_out_n <= 1'b0;
                  pwr_cmd_done_r <= 1'b1;
               end
               PS_UP_RST: begin
                  state_r <= PS_ON;
                  slot_reset_out_n <= 1'b1;
               end
               PS_DN_CLK: begin
                  state_r <= PS_DN_PWR;
                  tmr_r <= 32'(SEQ_P - 1);
                  slot_refclk_enable_out_n <= 1'b1;
               end
               PS_DN_PWR: begin
                  state_r <= PS_DN_WAIT;
                  tmr_r <= 32'(PWR_OFF_P - 2 * SEQ_P - 1);
                  slot_power_enable_out_n <= 1'b1;
               end
               PS_DN_WAIT: begin
                  state_r <= PS_OFF;
                  pwr_cmd_done_r <= 1'b1;
               end
               default:
                  state_r <= state_r;
            endcase
         end
      end
   end

   // power indicator drive
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         blink_cnt_r <= '0;
         blink_ph_r <= 1'b0;
         power_indicator_out_n <= 1'b1;
      end else if (ce) begin
         if (blink_cnt_r == 32'(BLINK_P - 1)) begin
            blink_cnt_r <= '0;
            blink_ph_r <= !blink_ph_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
         end
         case (ctrl_r.ind)
            IND_ON: power_indicator_out_n <= 1'b0;
            IND_BLINK: power_indicator_out_n <= blink_ph_r;
            default: power_indicator_out_n <= 1'b1;
         endcase
      end
   end

   // interrupt message generation
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         int_sent_r <= 1'b0;
         int_assert_msg <= 1'b0;
         int_deassert_msg <= 1'b0;
      end else if (ce) begin
         int_assert_msg <= 1'b0;
         int_deassert_msg <= 1'b0;
         if (hp_present && ctrl_r.hp_int_en && pend && !int_sent_r) begin
            int_sent_r <= 1'b1;
            int_assert_msg <= 1'b1;
         end else if (int_sent_r && !pend && ctrl_r.hp_int_en) begin
            int_sent_r <= 1'b0;
            int_deassert_msg <= 1'b1;
         end
      end
   end

   // register read port
   always_comb begin
      rdata_nxt = '0;
      if (hp_present) begin
         case (reg_addr)
            LINK_STAT_OFS: rdata_nxt[LINK_ACTIVE_BIT] = link_active;
            SLOT_CTRL_OFS: rdata_nxt = {stat_r, ctrl_r};
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rdata_nxt : '0;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst || !ce);

   sequence s_ind_write(logic [1:0] code);
      ind_cmd_done && ctrl_wr.ind == code;
   endsequence

   sequence s_cmd_flag;
      ##1 stat_r.cmd;
   endsequence

   AST_PRES_CHG: assert property (
      hp_present && $changed(stat_r.pres_st) |-> stat_r.pres_chg)
      else $error("presence change not flagged");

   AST_DEASSERT: assert property (
      int_deassert_msg |-> $past(ctrl_r.hp_int_en) && !$past(pend))
      else $error("deassert message without enable or with pending flag");

   AST_LATCH: assert property (
      hp_present && dbc_chg_r[DBC_LATCH] ##1 hp_present |->
      stat_r.latch_chg && stat_r.latch_st == $past(dbc_stable_r[DBC_LATCH]))
      else $error("latch change not recorded");

   AST_BTN: assert property (
      hp_present && btn_press ##1 hp_present |-> stat_r.btn)
      else $error("button press not recorded");

   AST_BLINK_CMD: assert property (
      s_ind_write(IND_BLINK) |-> s_cmd_flag)
      else $error("blink command not completed");

   AST_IND_ON: assert property (
      s_ind_write(IND_ON) |-> s_cmd_flag ##1 !power_indicator_out_n)
      else $error("indicator on command failed");

   AST_IND_OFF: assert property (
      s_ind_write(IND_OFF) |-> s_cmd_flag ##1 power_indicator_out_n)
      else $error("indicator off command failed");

   AST_PWR_UP: assert property (
      hp_present && !pwr_on_req && !pwr_off_req && state_r == PS_UP_VALID
      && tmr_r == '0 ##1 hp_present |->
      !slot_refclk_enable_out_n && !slot_power_enable_out_n ##1 stat_r.cmd)
      else $error("power up completion wrong");

   AST_PWR_OFF: assert property (
      hp_present && !pwr_on_req && !pwr_off_req && state_r == PS_DN_WAIT
      && tmr_r == '0 ##1 hp_present |->
      state_r == PS_OFF && slot_power_enable_out_n ##1 stat_r.cmd)
      else $error("power off completion wrong");

   AST_LINK_BIT: assert property (
      reg_rd && hp_present && reg_addr == LINK_STAT_OFS |=>
      reg_rdata[LINK_ACTIVE_BIT] == $past(link_active))
      else $error("link active bit wrong");

   AST_ABSENT: assert property (
      !hp_present |=> ctrl_r == hpsel_ctrl_t'(CTRL_RST) && !int_assert_msg)
      else $error("slot logic active on a port without it");

   AST_DEBOUNCE: assert property (
      $changed(dbc_stable_r[DBC_BTN]) |->
      $past(dbc_cnt_r[DBC_BTN]) == 32'(DEBOUNCE_P - 1))
      else $error("button taken before debounce interval");

   AST_DN_ORDER: assert property (
      state_r == PS_DN_PWR |-> !slot_reset_out_n &&
      slot_refclk_enable_out_n && !slot_power_enable_out_n)
      else $error("power down order wrong");

   AST_PWR_BIT: assert property (
      ctrl_write && ctrl_wr.pwr_off |=> ctrl_r.pwr_off)
      else $error("power control bit not stored");

   AST_HOLD_INT: assert property (
      int_sent_r && pend |=> !int_deassert_msg)
      else $error("interrupt withdrawn while flag pending");

endmodule

// ===== hpsel_slot_hw.sv
`timescale 1ns/10ps
module hpsel_slot_hw (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // operator actions
   input wire logic board_in,
   input wire logic latch_open,
   input wire logic press,
   // slot control from the controller, active low
   input wire logic slot_reset_out_n,
   input wire logic slot_refclk_enable_out_n,
   input wire logic slot_power_enable_out_n,
   // slot sense lines, active low; sequence fault flag, active high
   output logic presence_detect_n,
   output logic latch_sense_in_n,
   output logic attention_button_in_n,
   output logic seq_fault
);
   logic [2:0] bounce_r;
   logic press_r;
   // button contacts chatter for a few cycles after each press
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         press_r <= 1'b0;
         bounce_r <= 3'h0;
      end else begin
         press_r <= press;
         if (press && !press_r)
            bounce_r <= 3'h5;
         else if (bounce_r != 3'h0)
            bounce_r <= bounce_r - 3'h1;
      end
   end
   assign presence_detect_n = !board_in;
   assign latch_sense_in_n = latch_open;
   assign attention_button_in_n = !press ^ (press && bounce_r[0]);
   // a released slot reset needs clock and power, a running clock power
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         seq_fault <= 1'b0;
      else if ((slot_reset_out_n && slot_refclk_enable_out_n) ||
            (!slot_refclk_enable_out_n && slot_power_enable_out_n))
         seq_fault <= 1'b1;
   end
endmodule

// ===== tb_hot_plug_slot_event_logic.sv
`timescale 1ns/10ps
module tb_hot_plug_slot_event_logic;
   import hpsel_pkg::*;
   localparam int DBC = 8;
   localparam int PV = 10;
   localparam int RR = 10;
   localparam int SQ = 5;
   localparam int PO = 30;
   localparam int LIMIT = 5000;
   logic clk_sys, rst, ce, reg_wr, reg_rd, port_is_downstream, link_active;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
   logic board_in, latch_open, press, seq_fault, ok;
   logic presence_detect_n, latch_sense_in_n, attention_button_in_n;
   logic slot_reset_out_n, slot_refclk_enable_out_n;
   logic slot_power_enable_out_n, power_indicator_out_n;
   logic int_assert_msg, int_deassert_msg;
   logic prev_rst, prev_ck, prev_pw;
   logic [15:0] ctrl;
   logic [1:0] codes [3] = '{IND_BLINK, IND_ON, IND_OFF};
   int fails = 0, total_checks = 0, cyc = 0, n_as = 0, n_de = 0;
   int e_as = 0, e_de = 0, t_rst = 0, t_ck = 0, t_pw = 0, lows;

   hpsel_slot #(.PORT_NUM(1), .DEBOUNCE_P(DBC), .PWR_VALID_P(PV),
      .RST_REL_P(RR), .SEQ_P(SQ), .PWR_OFF_P(PO), .BLINK_P(4))
   u_hpsel_slot (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .port_is_downstream(port_is_downstream), .link_active(link_active),
      .presence_detect_n(presence_detect_n),
      .latch_sense_in_n(latch_sense_in_n),
      .attention_button_in_n(attention_button_in_n),
      .slot_reset_out_n(slot_reset_out_n),
      .slot_refclk_enable_out_n(slot_refclk_enable_out_n),
      .slot_power_enable_out_n(slot_power_enable_out_n),
      .power_indicator_out_n(power_indicator_out_n),
      .int_assert_msg(int_assert_msg), .int_deassert_msg(int_deassert_msg));

   hpsel_slot_hw u_hpsel_slot_hw (.clk_sys(clk_sys), .rst(rst),
      .board_in(board_in), .latch_open(latch_open), .press(press),
      .slot_reset_out_n(slot_reset_out_n),
      .slot_refclk_enable_out_n(slot_refclk_enable_out_n),
      .slot_power_enable_out_n(slot_power_enable_out_n),
      .presence_detect_n(presence_detect_n),
      .latch_sense_in_n(latch_sense_in_n),
      .attention_button_in_n(attention_button_in_n), .seq_fault(seq_fault));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fails = fails + 1;
         summarize();
      end
   end
   // message counts and pin change times
   always @(negedge clk_sys) begin
      if (int_assert_msg === 1'b1) n_as = n_as + 1;
      if (int_deassert_msg === 1'b1) n_de = n_de + 1;
      if (slot_reset_out_n !== prev_rst) t_rst = cyc;
      if (slot_refclk_enable_out_n !== prev_ck) t_ck = cyc;
      if (slot_power_enable_out_n !== prev_pw) t_pw = cyc;
      prev_rst = slot_reset_out_n;
      prev_ck = slot_refclk_enable_out_n;
      prev_pw = slot_power_enable_out_n;
   end

   task automatic chk32(input string nm, input logic [31:0] exp,
         input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk1(input string nm, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic slot_is(input string nm, input logic [15:0] s);
      rd(SLOT_CTRL_OFS, rv);
      chk32(nm, {s, ctrl}, rv);
   endtask
   task automatic msgs(input string nm);
      chk32({nm, " asserts"}, e_as, n_as);
      chk32({nm, " deasserts"}, e_de, n_de);
   endtask
   task automatic clr(input logic [15:0] b);
      wr(SLOT_CTRL_OFS, {b, ctrl});
      e_de++;
      idle(3);
   endtask
   task automatic pins(input logic r, input logic c, input logic p);
      @(negedge clk_sys);
      chk1("slot reset pin", r, slot_reset_out_n);
      chk1("refclk pin", c, slot_refclk_enable_out_n);
      chk1("power pin", p, slot_power_enable_out_n);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      port_is_downstream = 1'b1;
      link_active = 1'b0;
      board_in = 1'b0;
      latch_open = 1'b0;
      press = 1'b0;
      ctrl = CTRL_RST;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      pins(1'b0, 1'b1, 1'b1);
      slot_is("reset word", STAT_RST);
      rd(LINK_STAT_OFS, rv);
      chk32("link word low", 32'h0000_0000, rv);
      @(posedge clk_sys);
      link_active <= 1'b1;
      rd(LINK_STAT_OFS, rv);
      chk32("link word high", 32'h2000_0000, rv);
      rd(12'h084, rv);
      chk32("unmapped word", 32'h0000_0000, rv);
      $display("done: reset and register map");
      ctrl = CTRL_RST | 16'h003d;
      wr(SLOT_CTRL_OFS, {16'h0000, ctrl});
      e_as++;
      idle(3);
      slot_is("enable write completes", 16'h0010);
      msgs("enable");
      clr(16'h0010);
      slot_is("command flag cleared", 16'h0000);
      msgs("command clear");
      $display("done: enables and command clear");
      @(posedge clk_sys);
      board_in <= 1'b1;
      idle(4);
      e_as++;
      slot_is("board in", 16'h0048);
      clr(16'h0008);
      slot_is("presence ack", 16'h0040);
      msgs("presence");
      $display("done: insertion");
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         latch_open <= (i == 0);
         idle(3);
         slot_is("latch settling", i == 0 ? 16'h0040 : 16'h0060);
         idle(DBC);
         e_as++;
         slot_is("latch change", i == 0 ? 16'h0064 : 16'h0044);
         clr(16'h0004);
         msgs("latch");
      end
      $display("done: latch unlock and lock");
      @(posedge clk_sys);
      press <= 1'b1;
      idle(3);
      slot_is("button bouncing", 16'h0040);
      idle(16);
      e_as++;
      slot_is("button pressed", 16'h0041);
      @(posedge clk_sys);
      press <= 1'b0;
      idle(16);
      clr(16'h0001);
      slot_is("button ack", 16'h0040);
      msgs("button");
      $display("done: attention button");
      for (int i = 0; i < 3; i++) begin
         ctrl[9:8] = codes[i];
         wr(SLOT_CTRL_OFS, {16'h0000, ctrl});
         e_as++;
         idle(2);
         lows = 0;
         repeat (20) begin
            @(negedge clk_sys);
            lows += (power_indicator_out_n === 1'b0);
         end
         ok = i == 0 ? (lows > 0 && lows < 20) : lows == (i == 1 ? 20 : 0);
         chk1("indicator pattern", 1'b1, ok);
         slot_is("indicator command done", 16'h0050);
         clr(16'h0010);
         msgs("indicator");
      end
      $display("done: indicator commands");
      ctrl[10] = 1'b0;
      wr(SLOT_CTRL_OFS, {16'h0000, ctrl});
      idle(3);
      pins(1'b0, 1'b1, 1'b0);
      slot_is("power up pending", 16'h0040);
      idle(PV + 2);
      e_as++;
      slot_is("power up done", 16'h0050);
      idle(RR);
      pins(1'b1, 1'b0, 1'b0);
      chk1("valid delay", 1'b1, t_ck - t_pw inside {[PV:PV + 2]});
      clr(16'h0010);
      msgs("power up");
      ctrl[10] = 1'b1;
      wr(SLOT_CTRL_OFS, {16'h0000, ctrl});
      idle(2);
      pins(1'b0, 1'b0, 1'b0);
      idle(PO - 12);
      slot_is("power down pending", 16'h0040);
      idle(14);
      e_as++;
      slot_is("power down done", 16'h0050);
      pins(1'b0, 1'b1, 1'b1);
      chk1("clock stop gap", 1'b1, t_ck - t_rst inside {[SQ:SQ + 2]});
      chk1("power stop gap", 1'b1, t_pw - t_ck inside {[SQ:SQ + 2]});
      clr(16'h0010);
      msgs("power down");
      $display("done: slot power");
      @(posedge clk_sys);
      board_in <= 1'b0;
      press <= 1'b1;
      idle(20);
      e_as++;
      slot_is("two events", 16'h0009);
      clr(16'h0008);
      e_de--;
      msgs("one flag left");
      clr(16'h0001);
      msgs("all clear");
      $display("done: removal with pending button");
      @(posedge clk_sys);
      port_is_downstream <= 1'b0;
      rd(LINK_STAT_OFS, rv);
      chk32("absent link word", 32'h0000_0000, rv);
      rd(SLOT_CTRL_OFS, rv);
      chk32("absent slot word", 32'h0000_0000, rv);
      chk1("no sequence fault", 1'b0, seq_fault);
      $display("done: absent slot");
      summarize();
   end
endmodule
